//--- rtl/rsq_top.sv
// register self-test sequencer with apb status and fault injection
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// [RULE1] power-up traps to fixed start address
// [RULE2] start blocks inputs, clears display first
// [RULE3] write/verify K then files, print each
// [RULE4] failing check repeats its subtest forever
// [RULE5] failed register stops later prints, tests
// [RULE6] wait for keys, echo via scratch register
// [RULE7] terminate key ends echo, starts tests
// [RULE8] print number, run, error repeats, wrap
// [RULE9] test0 clear all then set ones
// [RULE10] scratch cleared alone first, loop till ok
// [RULE11] test1 step scratch, compare file one
// [RULE12] test2 chain scratch through files, compare
// [RULE13] test3 clear both status registers, check
// [RULE14] upper status checks ignore ready bit
// [RULE15] test4 step lower status versus file two
// [RULE16] test5 step upper status versus file zero
// [RULE17] test6 chain including lower status
// [RULE18] test7 load and verify shift patterns
// [RULE19] test8 rotate patterns, only target changes
// [RULE20] test9 control memory write then readback
// [RULE21] parity error shows address minus one
// [RULE22] after parity error hang until reset
// [RULE23] keyboard reset restarts from very start
// [RULE24] eight-bit registers, one strobed display byte
module rsq_top
   import rsq_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_key_valid,
   input  wire logic [7:0]  i_key_data,
   input  wire logic        i_key_reset,
   input  wire logic        i_ready_set,
   input  wire logic        i_cm_parity,
   input  wire logic        i_dm_parity,
   output logic      [7:0]  o_disp_data,
   output logic             o_disp_strobe,
   output logic             o_input_inhibit
);

   typedef struct packed {
      rsq_state_e        st;
      rsq_state_e        ret;
      rsq_msg_e          msg;
      logic [2:0]        pos;
      logic [7:0]        pch;
      logic [3:0]        idx;
      logic [3:0]        tnum;
      logic [7:0]        cnt;
      logic [7:0]        k;
      logic [7:0][7:0]   f;
      logic [7:0]        sh;
      logic [7:0]        sl;
      logic [7:0]        ph;
      logic [7:0]        pl;
      logic [3:0][23:0]  cm;
      logic [15:0]       pc;
      logic [15:0]       eaddr;
      logic              inh;
      logic [7:0]        dd;
      logic              ds;
      logic              hold;
      logic [3:0]        fsel;
      logic [7:0]        fmask;
      logic              fail;
      logic [7:0]        passes;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } rsq_state_s;

   rsq_state_s r;
   rsq_state_s next_r;
   logic [13:0][7:0] m;

   // per-register read fault masks
   for (genvar g = 0; g < 14; g++) begin : g_mask
      assign m[g] = (r.fsel == 4'(g)) ? r.fmask : 8'h00;
   end

   function automatic logic [7:0] hexc(input logic [3:0] v);
      return (v < 4'hA) ? CH_0 + {4'h0, v} : 8'h37 + {4'h0, v};
   endfunction

   // {last, char} of a message at a position
   function automatic logic [8:0] mchar(input rsq_msg_e mm, input logic [2:0] p,
                                        input logic [7:0] c, input logic [15:0] a);
      logic [8:0] o;
      o = {1'b1, c};
      unique case (mm)
         M_CHR: o = {1'b1, c};
         M_ERR: o = {p == 3'd4, (p == 3'd0) ? 8'h45 : (p == 3'd3) ? 8'h4F : 8'h52};
         M_PE: begin
            unique case (p)
               3'd0: o = {1'b0, 8'h50};
               3'd1: o = {1'b0, 8'h45};
               3'd2: o = {1'b0, 8'h20};
               3'd3: o = {1'b0, hexc(a[15:12])};
               3'd4: o = {1'b0, hexc(a[11:8])};
               3'd5: o = {1'b0, hexc(a[7:4])};
               default: o = {1'b1, hexc(a[3:0])};
            endcase
         end
         default: o = {1'b1, c};
      endcase
      return o;
   endfunction

   function automatic logic [7:0] pat(input logic [2:0] i);
      unique case (i)
         3'd0, 3'd2, 3'd6: return PAT_A;
         3'd3: return PAT_C;
         3'd4: return PAT_D;
         default: return PAT_B;
      endcase
   endfunction

   // pattern after move mv: complement, doubled high nibble, its complement, back
   function automatic logic [7:0] rot(input logic [7:0] p, input logic [1:0] mv);
      unique case (mv)
         2'd0: return ~p;
         2'd1: return {p[7:4], p[7:4]};
         2'd2: return ~{p[7:4], p[7:4]};
         default: return p;
      endcase
   endfunction

   always_comb begin
      logic [7:0] v;
      logic [8:0] mc;
      logic       ok;
      logic       done;
      logic       wr;
      logic [7:0] exp;
      logic       fset;
      v = 8'h00;
      ok = 1'b1;
      done = 1'b0;
      exp = 8'h00;
      fset = 1'b0;
      next_r = r;
      next_r.ds = 1'b0;
      mc = mchar(r.msg, r.pos, r.pch, r.eaddr);
      wr = i_psel & i_penable & r.pready & i_pwrite;

      // apb slave: no wait state, answer registered from the setup cycle, shown in the first access cycle
      next_r.pready = i_psel & ~i_penable & ~r.pready;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      if (i_psel & ~i_penable) begin
         unique case (i_paddr)
            OFS_CTRL:  next_r.prdata = {31'h0, r.hold};
            OFS_STAT:  next_r.prdata = {16'h0, r.fail, r.st == S_HANG, 2'b00,
                                        r.tnum, 3'b000, r.st};
            OFS_FAULT: next_r.prdata = {16'h0, r.fmask, 4'h0, r.fsel};
            OFS_ADDR:  next_r.prdata = {r.eaddr, r.pc};
            OFS_PASS:  next_r.prdata = {24'h0, r.passes};
            default:   next_r.pslverr = 1'b1;
         endcase
      end
      if (wr && i_paddr == OFS_CTRL) begin
         next_r.hold = i_pwdata[CTRL_HOLD];
      end
      if (wr && i_paddr == OFS_FAULT) begin
         next_r.fsel = i_pwdata[3:0];
         next_r.fmask = i_pwdata[15:8];
      end

      if (!r.hold && r.st != S_HANG) begin
         next_r.pc = r.pc + 16'h0001;
      end

      if (!r.hold) begin
         unique case (r.st)
            S_TRAP: begin
               next_r.pc = TRAP_ADDR; // [RULE1]
               next_r.st = S_START;
            end
            S_START: begin
               next_r.inh = 1'b1; // [RULE2]
               next_r.msg = M_CHR;
               next_r.pos = 3'd0;
               next_r.pch = CH_CLR;
               next_r.idx = IDX_K;
               next_r.ret = S_INIT_W;
               next_r.st = S_PRINT;
            end
            S_INIT_W: begin
               if (r.idx == IDX_K) next_r.k = CH_K; // [RULE3]
               else next_r.f[r.idx[2:0]] = CH_0 + {5'h0, r.idx[2:0]};
               next_r.st = S_INIT_C;
            end
            S_INIT_C: begin
               if (r.idx == IDX_K) begin
                  v = r.k ^ m[IDX_K];
                  ok = v == CH_K;
               end else begin
                  v = r.f[r.idx[2:0]] ^ m[r.idx[2:0]];
                  ok = v == CH_0 + {5'h0, r.idx[2:0]};
               end
               if (ok) begin
                  next_r.msg = M_CHR; // [RULE3]
                  next_r.pos = 3'd0;
                  next_r.pch = v;
                  next_r.idx = (r.idx == IDX_K) ? 4'h0 : r.idx + 4'h1;
                  next_r.ret = (r.idx == 4'h7) ? S_ECHO : S_INIT_W;
                  next_r.st = S_PRINT;
               end else begin
                  next_r.fail = 1'b1;
                  fset = 1'b1;
                  next_r.st = S_INIT_W; // [RULE4] [RULE5]
               end
            end
            S_ECHO: begin
               next_r.inh = 1'b0;
               if (i_key_valid) begin
                  if (i_key_data == KEY_TERM) begin
                     next_r.inh = 1'b1;
                     next_r.st = S_PRE_W; // [RULE7]
                  end else begin
                     next_r.k = i_key_data; // [RULE6]
                     next_r.msg = M_CHR;
                     next_r.pos = 3'd0;
                     next_r.pch = i_key_data ^ m[IDX_K];
                     next_r.ret = S_ECHO;
                     next_r.st = S_PRINT;
                  end
               end
            end
            S_PRE_W: begin
               next_r.k = 8'h00; // [RULE10]
               next_r.st = S_PRE_C;
            end
            S_PRE_C: begin
               next_r.tnum = 4'h0;
               next_r.st = ((r.k ^ m[IDX_K]) == 8'h00) ? S_TNUM : S_PRE_W; // [RULE10]
            end
            S_TNUM: begin
               next_r.cnt = 8'h00;
               if (r.tnum == 4'h8) begin
                  for (int i = 0; i < 8; i++) next_r.f[i] = pat(3'(i));
               end
               next_r.msg = M_CHR; // [RULE8]
               next_r.pos = 3'd0;
               next_r.pch = CH_0 + {4'h0, r.tnum};
               next_r.ret = S_TW;
               next_r.st = S_PRINT;
            end
            S_TW: begin
               next_r.st = S_TC;
               unique case (r.tnum)
                  4'h0: begin
                     v = r.cnt[0] ? ALL_ONES : 8'h00; // [RULE9]
                     next_r.k = v;
                     for (int i = 0; i < 8; i++) next_r.f[i] = v;
                  end
                  4'h1: begin
                     next_r.k = (r.cnt == 8'h00) ? 8'h00 : (r.k ^ m[IDX_K]) + 8'h01; // [RULE11]
                     next_r.f[1] = r.cnt;
                  end
                  4'h2, 4'h6: begin
                     v = r.cnt; // [RULE12]
                     next_r.k = v;
                     v = v ^ m[IDX_K];
                     if (r.tnum == 4'h6) begin
                        next_r.sl = v; // [RULE17]
                        v = v ^ m[SEL_SL];
                     end
                     for (int i = 0; i < 8; i++) begin
                        next_r.f[i] = v;
                        v = v ^ m[i];
                     end
                  end
                  4'h3: begin
                     next_r.sl = 8'h00; // [RULE13]
                     next_r.sh = 8'h00;
                  end
                  4'h4: begin
                     next_r.sl = r.cnt; // [RULE15]
                     next_r.f[2] = r.cnt;
                  end
                  4'h5: begin
                     next_r.sh = r.cnt; // [RULE16]
                     next_r.f[0] = r.cnt;
                  end
                  4'h7: begin
                     for (int i = 0; i < 8; i++) next_r.f[i] = pat(3'(i)); // [RULE18]
                  end
                  4'h8: begin
                     next_r.f[r.cnt[4:2]] = rot(pat(r.cnt[4:2]), r.cnt[1:0]); // [RULE19]
                  end
                  default: begin
                     if (r.cnt == 8'h00) begin
                        next_r.k = PAT_B; // [RULE20]
                        next_r.ph = PAT_A;
                        next_r.pl = PAT_A;
                     end else if (r.cnt == 8'h01) begin
                        next_r.cm[CM_LOC] = {r.k ^ m[IDX_K], r.ph ^ m[SEL_PH],
                                             r.pl ^ m[SEL_PL]};
                        next_r.k = 8'h00;
                        next_r.ph = 8'h00;
                        next_r.pl = 8'h00;
                     end else begin
                        {next_r.k, next_r.ph, next_r.pl} = r.cm[CM_LOC] ^ {3{m[SEL_CM]}};
                     end
                  end
               endcase
               if (i_ready_set) next_r.sh = next_r.sh | RDY_BIT;
            end
            S_TC: begin
               unique case (r.tnum)
                  4'h0: begin
                     exp = r.cnt[0] ? ALL_ONES : 8'h00; // [RULE9]
                     ok = (r.k ^ m[IDX_K]) == exp;
                     for (int i = 0; i < 8; i++) ok = ok && ((r.f[i] ^ m[i]) == exp);
                     done = r.cnt == 8'h01;
                  end
                  4'h1: begin
                     ok = (r.k ^ m[IDX_K]) == (r.f[1] ^ m[1]); // [RULE11]
                     done = r.cnt == ALL_ONES;
                  end
                  4'h2, 4'h6: begin
                     ok = (r.f[7] ^ m[7]) == (r.k ^ m[IDX_K]); // [RULE12] [RULE17]
                     done = r.cnt == ALL_ONES;
                  end
                  4'h3: begin
                     ok = ((r.sl ^ m[SEL_SL]) == 8'h00) &&
                          (((r.sh ^ m[SEL_SH]) & ~RDY_BIT) == 8'h00); // [RULE13] [RULE14]
                     done = 1'b1;
                  end
                  4'h4: begin
                     ok = (r.sl ^ m[SEL_SL]) == (r.f[2] ^ m[2]); // [RULE15]
                     done = r.cnt == ALL_ONES;
                  end
                  4'h5: begin
                     ok = (((r.sh ^ m[SEL_SH]) ^ (r.f[0] ^ m[0])) & ~RDY_BIT) == 8'h00; // [RULE14] [RULE16]
                     done = r.cnt == ALL_ONES;
                  end
                  4'h7: begin
                     for (int i = 0; i < 8; i++) ok = ok && ((r.f[i] ^ m[i]) == pat(3'(i))); // [RULE18]
                     done = 1'b1;
                  end
                  4'h8: begin
                     for (int i = 0; i < 8; i++) begin
                        exp = (3'(i) == r.cnt[4:2]) ? rot(pat(3'(i)), r.cnt[1:0]) : pat(3'(i));
                        ok = ok && ((r.f[i] ^ m[i]) == exp); // [RULE19]
                     end
                     done = r.cnt == 8'h1F;
                  end
                  default: begin
                     ok = (r.cnt != 8'h02) ||
                          ({r.k ^ m[IDX_K], r.ph ^ m[SEL_PH], r.pl ^ m[SEL_PL]} ==
                           {PAT_B, PAT_A, PAT_A}); // [RULE20]
                     done = r.cnt == 8'h02;
                  end
               endcase
               if (!ok) begin
                  next_r.fail = 1'b1; // [RULE4] [RULE8]
                  fset = 1'b1;
                  next_r.msg = M_ERR;
                  next_r.pos = 3'd0;
                  next_r.ret = S_TNUM;
                  next_r.st = S_PRINT;
               end else if (done) begin
                  next_r.tnum = (r.tnum == LAST_TEST) ? 4'h0 : r.tnum + 4'h1; // [RULE8]
                  if (r.tnum == LAST_TEST) next_r.passes = r.passes + 8'h01;
                  next_r.st = S_TNUM;
               end else begin
                  next_r.cnt = r.cnt + 8'h01;
                  next_r.st = S_TW;
               end
            end
            S_PRINT: begin
               next_r.dd = mc[7:0]; // [RULE24]
               next_r.ds = 1'b1;
               next_r.pos = r.pos + 3'd1;
               if (mc[8]) next_r.st = r.ret;
            end
            S_HANG: begin
               next_r.st = S_HANG; // [RULE22]
            end
            default: next_r.st = S_TRAP;
         endcase
         if ((i_cm_parity | i_dm_parity) && r.st != S_HANG &&
             !(r.st == S_PRINT && r.msg == M_PE)) begin
            next_r.eaddr = r.pc - 16'h0001; // [RULE21]
            next_r.msg = M_PE;
            next_r.pos = 3'd0;
            next_r.ret = S_HANG; // [RULE22]
            next_r.st = S_PRINT;
         end
      end
      // the ready bit may be set by attached devices at any time
      if (i_ready_set) next_r.sh = next_r.sh | RDY_BIT;
      if (i_key_reset || (wr && i_paddr == OFS_CTRL && i_pwdata[CTRL_RSTR])) begin
         next_r.st = S_TRAP; // [RULE23]
         next_r.inh = 1'b1;
         next_r.fail = fset; // a fault in the restart cycle wins
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
         r.st <= S_TRAP;
         r.inh <= 1'b1;
         r.pc <= TRAP_ADDR;
         r.fsel <= FSEL_RST;
         r.fmask <= FMASK_RST;
      end else begin
         r <= next_r;
      end
   end

   assign o_prdata = r.prdata;
   assign o_pready = r.pready;
   assign o_pslverr = r.pslverr;
   assign o_disp_data = r.dd;
   assign o_disp_strobe = r.ds;
   assign o_input_inhibit = r.inh;

endmodule // rsq_top
`default_nettype wire

//--- common/rsq_pkg.sv
// constants and types for the register self-test sequencer
package rsq_pkg;
   localparam logic [15:0] TRAP_ADDR = 16'h8003;
   localparam logic [7:0]  CH_K      = 8'h4B;
   localparam logic [7:0]  CH_0      = 8'h30;
   localparam logic [7:0]  CH_CLR    = 8'h03;
   localparam logic [7:0]  KEY_TERM  = 8'h0D;
   localparam logic [7:0]  RDY_BIT   = 8'h08;
   localparam logic [7:0]  ALL_ONES  = 8'hFF;
   localparam logic [7:0]  PAT_A     = 8'h5A;
   localparam logic [7:0]  PAT_B     = 8'hA5;
   localparam logic [7:0]  PAT_C     = 8'h55;
   localparam logic [7:0]  PAT_D     = 8'hAA;
   localparam logic [1:0]  CM_LOC    = 2'h1;
   localparam logic [3:0]  LAST_TEST = 4'h9;
   localparam logic [3:0]  IDX_K     = 4'h8;
   // fault select codes beyond file registers 0..7
   localparam logic [3:0]  SEL_SL    = 4'h9;
   localparam logic [3:0]  SEL_SH    = 4'hA;
   localparam logic [3:0]  SEL_PH    = 4'hB;
   localparam logic [3:0]  SEL_PL    = 4'hC;
   localparam logic [3:0]  SEL_CM    = 4'hD;
   // apb register byte offsets
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_STAT  = 12'h004;
   localparam logic [11:0] OFS_FAULT = 12'h008;
   localparam logic [11:0] OFS_ADDR  = 12'h00C;
   localparam logic [11:0] OFS_PASS  = 12'h010;
   localparam int          CTRL_HOLD = 0;
   localparam int          CTRL_RSTR = 1;
   localparam logic [3:0]  FSEL_RST  = 4'hF;
   localparam logic [7:0]  FMASK_RST = 8'h00;

   typedef enum logic [4:0] {
      S_TRAP, S_START, S_INIT_W, S_INIT_C, S_ECHO, S_PRE_W, S_PRE_C,
      S_TNUM, S_TW, S_TC, S_PRINT, S_HANG
   } rsq_state_e;

   typedef enum logic [1:0] {M_CHR, M_ERR, M_PE} rsq_msg_e;
endpackage

//--- testbench/rsq_props.sv
// concurrent checks on the sequencer's display and keyboard ports
`timescale 1ns/100ps
`default_nettype none
module rsq_props
   import rsq_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_key_valid,
   input wire logic [7:0] i_key_data,
   input wire logic       i_key_reset,
   input wire logic       i_cm_parity,
   input wire logic       i_dm_parity,
   input wire logic [7:0] o_disp_data,
   input wire logic       o_disp_strobe,
   input wire logic       o_input_inhibit
);
   logic [1:0] n;
   logic       pe;
   logic [3:0] pn;
   // bytes since restart, and bytes since a parity error
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         n  <= 2'h0;
         pe <= 1'b0;
         pn <= 4'h0;
      end else if (i_key_reset) begin
         n  <= 2'h0;
         pe <= 1'b0;
         pn <= 4'h0;
      end else begin
         if (o_disp_strobe && n != 2'h3) n <= n + 2'h1;
         if (i_cm_parity || i_dm_parity) pe <= 1'b1;
         if (pe && o_disp_strobe && pn != 4'hF) pn <= pn + 4'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_reset_inhibit: assert property (
      $fell(i_rst) |-> o_input_inhibit && !o_disp_strobe) else $error("inhibit low at start");
   a_first_clear: assert property (
      o_disp_strobe && n == 2'h0 && !$past(i_key_reset) |-> o_disp_data == CH_CLR)
      else $error("first byte is not a clear");
   a_init_k: assert property (
      o_disp_strobe && n == 2'h1 |-> o_disp_data == CH_K) else $error("second byte not K");
   a_init_zero: assert property (
      o_disp_strobe && n == 2'h2 |-> o_disp_data == CH_0) else $error("third byte not 0");
   a_echo_byte: assert property (
      i_key_valid && !o_input_inhibit && i_key_data != KEY_TERM
      |-> ##2 o_disp_strobe && o_disp_data == $past(i_key_data, 2)) else $error("no echo");
   a_term_leaves: assert property (
      i_key_valid && !o_input_inhibit && i_key_data == KEY_TERM |-> ##[1:4] o_input_inhibit)
      else $error("echo not left");
   a_keyrst_clear: assert property (
      $rose(i_key_reset) |-> ##[1:8] o_disp_strobe && o_disp_data == CH_CLR)
      else $error("key reset did not restart");
   a_pe_prefix: assert property (
      pe && pn == 4'h0 && o_disp_strobe |-> o_disp_data == 8'h50) else $error("bad PE text");
   a_pe_hang: assert property (
      pe && pn == 4'h7 |-> !o_disp_strobe) else $error("output after parity hang");
endmodule // rsq_props
bind rsq_top rsq_props u_rsq_props (
   .i_clk(i_clk), .i_rst(i_rst), .i_key_valid(i_key_valid), .i_key_data(i_key_data),
   .i_key_reset(i_key_reset), .i_cm_parity(i_cm_parity), .i_dm_parity(i_dm_parity),
   .o_disp_data(o_disp_data), .o_disp_strobe(o_disp_strobe),
   .o_input_inhibit(o_input_inhibit)
);
`default_nettype wire

//--- testbench/rsq_term.sv
// operator terminal model: keyboard sender and display capture
`timescale 1ns/100ps
`default_nettype none
module rsq_term
   import rsq_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_disp_data,
   input  wire logic       i_disp_strobe,
   input  wire logic       i_input_inhibit,
   output var  logic       o_key_valid,
   output var  logic [7:0] o_key_data
);
   logic [7:0] rx[$];
   initial begin
      o_key_valid = 1'b0;
      o_key_data  = 8'h00;
   end
   always @(posedge i_clk) begin
      if (i_disp_strobe === 1'b1) rx.push_back(i_disp_data);
   end
   // a key goes out only while input is open, then the line is scrambled
   task automatic send_key(input logic [7:0] k);
      while (i_input_inhibit !== 1'b0) begin
         @(posedge i_clk);
      end
      o_key_valid <= 1'b1;
      o_key_data  <= k;
      @(posedge i_clk);
      o_key_valid <= 1'b0;
      o_key_data  <= ~k;
      repeat (4) @(posedge i_clk);
   endtask
endmodule // rsq_term
`default_nettype wire

//--- testbench/test_rsq_top.sv
// self-checking bench for the register self-test sequencer
`timescale 1ns/100ps
`default_nettype none
module test_rsq_top
   import rsq_pkg::*;
   ;
   typedef struct {logic [11:0] a; logic [31:0] v; logic e;} rsq_row_s;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, krst = 1'b0;
   logic        rdy = 1'b0, cmp = 1'b0, dmp = 1'b0, pready, pslverr, err, kv, ds, inh;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  kd, dd;
   logic        f;
   logic [15:0] pa;
   logic [3:0]  hx;
   int          errors = 0;
   int          checked = 0;
   rsq_row_s    rows[5] = '{'{OFS_FAULT, 32'h0000000F, 1'b0}, '{OFS_CTRL, 32'h0, 1'b0},
                           '{OFS_STAT, 32'h4, 1'b0}, '{12'h014, 32'h0, 1'b1},
                           '{12'hFFC, 32'h0, 1'b1}};
   always #10 i_clk = ~i_clk;
   rsq_top u_rsq_top (
      .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_key_valid(kv), .i_key_data(kd), .i_key_reset(krst),
      .i_ready_set(rdy), .i_cm_parity(cmp), .i_dm_parity(dmp), .o_disp_data(dd),
      .o_disp_strobe(ds), .o_input_inhibit(inh));
   rsq_term u_rsq_term (
      .i_clk(i_clk), .i_disp_data(dd), .i_disp_strobe(ds), .i_input_inhibit(inh),
      .o_key_valid(kv), .o_key_data(kd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1) begin
         @(posedge i_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wait_rx(input int n, input int lim);
      for (int t = 0; t < lim && u_rsq_term.rx.size() < n; t++) @(posedge i_clk);
   endtask
   task automatic expect_str(input string s, input int lim);
      wait_rx(s.len(), lim);
      check(u_rsq_term.rx.size() >= s.len(), 1'b1);
      for (int i = 0; i < s.len() && u_rsq_term.rx.size() > 0; i++) begin
         check(u_rsq_term.rx.pop_front(), s[i]);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge i_clk);
      errors++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge i_clk);
      check(inh, 1'b1);
      i_rst <= 1'b0;
      apb(1'b0, OFS_ADDR, 32'h0);
      check(rd[15:0], TRAP_ADDR);
      expect_str("\003K01234567", 2000);
      $display("test init done");
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].v);
         check(err, rows[i].e);
      end
      $display("test registers done");
      u_rsq_term.send_key(8'h41);
      u_rsq_term.send_key(8'h7A);
      check(inh, 1'b0);
      expect_str("Az", 50);
      $display("test echo done");
      for (int p = 0; p < 2; p++) begin
         // counter sampled at setup; parity lands three edges later, shown minus one
         apb(1'b0, OFS_ADDR, 32'h0);
         pa = rd[15:0] + 16'h0002;
         if (p == 0) cmp <= 1'b1;
         else dmp <= 1'b1;
         @(posedge i_clk);
         cmp <= 1'b0;
         dmp <= 1'b0;
         expect_str("PE ", 100);
         repeat (300) @(posedge i_clk);
         check(u_rsq_term.rx.size(), 4);
         for (int i = 0; i < 4; i++) begin
            hx = pa[15-4*i -: 4];
            check(u_rsq_term.rx.pop_front(), (hx < 4'hA) ? 8'h30 + hx : 8'h37 + hx);
         end
         apb(1'b0, OFS_STAT, 32'h0);
         check(rd[14], 1'b1);
         u_rsq_term.rx.delete();
         krst <= 1'b1;
         @(posedge i_clk);
         krst <= 1'b0;
         expect_str("\003K01234567", 2000);
      end
      $display("test parity done");
      apb(1'b1, OFS_FAULT, 32'h00000102);
      apb(1'b1, OFS_CTRL, 32'h00000002);
      expect_str("\003K01", 500);
      repeat (300) @(posedge i_clk);
      check(u_rsq_term.rx.size(), 0);
      apb(1'b0, OFS_STAT, 32'h0);
      check(rd[4:0] == 5'h2 || rd[4:0] == 5'h3, 1'b1);
      apb(1'b1, OFS_FAULT, 32'h0000000F);
      expect_str("234567", 500);
      $display("test init fault done");
      rdy <= 1'b1;
      u_rsq_term.send_key(KEY_TERM);
      check(inh, 1'b1);
      expect_str("01234567890", 40000);
      $display("test loop done");
      apb(1'b1, OFS_FAULT, 32'h00000101);
      u_rsq_term.rx.delete();
      wait_rx(20, 20000);
      apb(1'b1, OFS_FAULT, 32'h0000000F);
      apb(1'b0, OFS_STAT, 32'h0);
      check(rd[15], 1'b1);
      f = 1'b0;
      for (int i = 1; i + 5 < u_rsq_term.rx.size(); i++) begin
         if ({u_rsq_term.rx[i], u_rsq_term.rx[i+1], u_rsq_term.rx[i+2], u_rsq_term.rx[i+3],
              u_rsq_term.rx[i+4]} == 40'h4552524F52 &&
             u_rsq_term.rx[i+5] == u_rsq_term.rx[i-1]) f = 1'b1;
      end
      check(f, 1'b1);
      $display("test error repeat done");
      end_of_test();
   end
endmodule // test_rsq_top
`default_nettype wire
